// ### pkg/psf_consts.vh
/*
  Constants for the pressure sample buffer: register offsets, field positions,
  reset values and sizes. Included by the trim loader and the core; the staging FIFO does not include it.
*/
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH

// Register offsets
`define PSF_ADDR_THRESH_CFG    8'h0b
`define PSF_ADDR_INT_ROUTE     8'h12
`define PSF_ADDR_MODE_CTRL     8'h14
`define PSF_ADDR_WTM_LEVEL     8'h15
`define PSF_ADDR_INT_SOURCE    8'h24
`define PSF_ADDR_SAMPLE_COUNT  8'h25
`define PSF_ADDR_FLAG_STATUS   8'h26
`define PSF_ADDR_PRESS_XL      8'h28
`define PSF_ADDR_PRESS_L       8'h29
`define PSF_ADDR_PRESS_H       8'h2a
`define PSF_ADDR_TEMP_L        8'h2b
`define PSF_ADDR_TEMP_H        8'h2c
`define PSF_ADDR_BUF_XL        8'h78
`define PSF_ADDR_BUF_L         8'h79
`define PSF_ADDR_BUF_H         8'h7a

// Mode control fields
`define PSF_MODE_LSB           0
`define PSF_MODE_MSB           1
`define PSF_TRIG_BIT           2
`define PSF_STOP_WTM_BIT       3

// Interrupt routing enables
`define PSF_EN_DRDY_BIT        0
`define PSF_EN_OVR_BIT         2
`define PSF_EN_WTM_BIT         3
`define PSF_EN_FULL_BIT        4

// Flag status fields
`define PSF_ST_WTM_BIT         7
`define PSF_ST_OVR_BIT         6
`define PSF_ST_FULL_BIT        5

// Reset values
`define PSF_RST_BYTE           8'h00
`define PSF_RST_PRESS          24'h000000
`define PSF_RST_TEMP           16'h0000

// Sizes
`define PSF_DEPTH              8'h80
`define PSF_STAGE_DEPTH        16
`define PSF_STAGE_AW           4
`define PSF_TRIM_WORDS         4

`endif

// ### rtl/psf_stage_fifo.v
/*
  Staging FIFO between the conversion engine and the sample buffer core.
  Assumes both sides run on sys_clk; a word moves when valid and ready are both high.
*/
`timescale 1ns/1ps
module psf_stage_fifo #(
  parameter W     = 40,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         sys_clk,
  input  wire         reset,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output reg  [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0]   count_q;
  wire         push;
  wire         pop;

  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    out_data = mem[rd_ptr_q];
  end

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ### rtl/psf_trim_loader.v
/*
  Copies trimming bytes from nonvolatile storage into working registers after reset.
  Assumes the storage returns data one cycle after a read request.
*/
`timescale 1ns/1ps
`include "psf_consts.vh"
module psf_trim_loader (
  input  wire                         sys_clk,
  input  wire                         reset,
  output reg  [1:0]                   nv_rd_addr,
  output wire                         nv_rd_en,
  input  wire [7:0]                   nv_rd_data,
  output reg  [8*`PSF_TRIM_WORDS-1:0] trim_values,
  output wire                         trim_done
);
  localparam ST_REQ  = 2'd0;
  localparam ST_CAP  = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [1:0] state_q;

  assign nv_rd_en  = (state_q == ST_REQ);
  assign trim_done = (state_q == ST_DONE);

  always @(posedge sys_clk) begin
    if (reset) begin
      state_q     <= ST_REQ;
      nv_rd_addr  <= 2'd0;
      trim_values <= {(8*`PSF_TRIM_WORDS){1'b0}};
    end else begin
      case (state_q)
        ST_REQ: begin
          state_q <= ST_CAP;
        end
        ST_CAP: begin
          trim_values[nv_rd_addr*8 +: 8] <= nv_rd_data;
          if (nv_rd_addr == 2'd3) begin
            state_q <= ST_DONE;
          end else begin
            nv_rd_addr <= nv_rd_addr + 2'd1;
            state_q    <= ST_REQ;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_REQ;
        end
      endcase
    end
  end
endmodule

// ### rtl/psf_core.v
/*
  Pressure sample buffer: result registers, 128-entry pressure FIFO with its modes,
  watermark, overrun, sample count, data-ready and interrupt routing.
  Assumes a serial interface front end that issues single-cycle register strobes
  on sys_clk and follows reg_next_addr for burst reads; conversion results and the
  threshold generator flag come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "psf_consts.vh"
// Notes on behaviour
// - Buffer holds up to 128 pressure entries of 24 bits each.
// - Buffer active for codes 001, 011, 101, 110 and 111; trigger bit plus mode field pick behaviour.
// - Watermark flag set when unread count reaches or exceeds the watermark level.
// - Watermark level zero keeps the watermark flag low.
// - Overwriting an unread entry sets the overrun flag.
// - Eight-bit count of unread entries; 0 is empty, 128 is full.
// - Codes 000 and 100 bypass the buffer, which stays empty and is cleared.
// - Bypass keeps only the latest sample, overwriting the older one.
// - Code 001 stores samples until full, then drops new ones.
// - Stop-at-watermark bit limits usable depth to the watermark level.
// - Code 011 stores continuously; after draining, the next sample is read first.
// - Watermark, overrun and full events routable to the interrupt pin by enables.
// - Code 101 bypasses until interrupt-active rises, then stops when full.
// - Code 110 bypasses until interrupt-active rises, then stores continuously.
// - Pressure result is 24-bit signed across 28h, 29h, 2Ah.
// - Pressure codes scale at 4096 steps per hectopascal.
// - Buffered entries use the same format at 78h through 7Ah.
// - Temperature is 16-bit signed at 2Bh and 2Ch, 100 steps per degree.
// - Data-ready asserted when a new pressure and temperature pair is available.
// - Trimming values copied from nonvolatile storage before measurement starts.
// - Buffer reads auto-advance, wrapping from 7Ah to 78h; full drain 384 bytes.
// - Code 111 stores continuously until interrupt-active rises, then stops when full.
module psf_core (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output wire [7:0]  reg_next_addr,
  input  wire [23:0] sample_pressure,
  input  wire [15:0] sample_temperature,
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire        interrupt_active,
  input  wire [7:0]  interrupt_source,
  output wire [7:0]  threshold_interrupt_config,
  output reg         interrupt_ready_pin,
  output wire [1:0]  nv_rd_addr,
  output wire        nv_rd_en,
  input  wire [7:0]  nv_rd_data,
  output wire [31:0] trim_values,
  output wire        trim_done
);
  localparam B_BYPASS = 2'd0;
  localparam B_FIFO   = 2'd1;
  localparam B_CONT   = 2'd2;

  reg  [7:0]  thresh_cfg_q;
  reg  [7:0]  int_route_q;
  reg  [7:0]  mode_ctrl_q;
  reg  [7:0]  wtm_level_q;
  reg  [23:0] press_q;
  reg  [15:0] temp_q;
  reg  [23:0] buf_mem [0:127];
  reg  [6:0]  wr_ptr_q;
  reg  [6:0]  rd_ptr_q;
  reg  [7:0]  count_q;
  reg  [7:0]  count_d;
  reg         ovr_q;
  reg         drdy_q;
  reg         trig_seen_q;
  reg         ia_prev_q;
  reg  [1:0]  behave;
  reg  [7:0]  rdata_d;
  reg         push;
  reg         drop_oldest;
  wire [2:0]  mode_code;
  wire        stop_at_watermark;
  wire [6:0]  watermark_level;
  wire [7:0]  depth_limit;
  wire        ia_rise;
  wire        ctrl_wr;
  wire        clear_buf;
  wire        pop;
  wire        fifo_addr;
  wire        st_valid;
  wire        st_ready;
  wire [39:0] st_data;
  wire        take;
  wire        wtm_flag;
  wire        full_flag;
  wire [23:0] head;

  assign mode_code         = {mode_ctrl_q[`PSF_TRIG_BIT], mode_ctrl_q[`PSF_MODE_MSB:`PSF_MODE_LSB]};
  assign stop_at_watermark = mode_ctrl_q[`PSF_STOP_WTM_BIT];
  assign watermark_level   = wtm_level_q[6:0];
  assign threshold_interrupt_config = thresh_cfg_q;

  // Power-on copy of trimming bytes; sampling waits for it
  psf_trim_loader u_trim (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .nv_rd_addr  (nv_rd_addr),
    .nv_rd_en    (nv_rd_en),
    .nv_rd_data  (nv_rd_data),
    .trim_values (trim_values),
    .trim_done   (trim_done)
  );

  psf_stage_fifo #(
    .W     (40),
    .DEPTH (`PSF_STAGE_DEPTH),
    .AW    (`PSF_STAGE_AW)
  ) u_stage (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   ({sample_temperature, sample_pressure}),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (st_data),
    .out_valid (st_valid),
    .out_ready (st_ready)
  );

  assign fifo_addr = (reg_addr == `PSF_ADDR_BUF_XL) || (reg_addr == `PSF_ADDR_BUF_L) ||
                     (reg_addr == `PSF_ADDR_BUF_H);
  // Hold new samples while trimming loads, a buffer read or a mode write is in flight
  assign st_ready  = trim_done & ~(reg_rd & fifo_addr) & ~ctrl_wr;
  assign take      = st_valid & st_ready;

  // Burst address wraps inside the buffered output window
  assign reg_next_addr = (reg_addr == `PSF_ADDR_BUF_H) ? `PSF_ADDR_BUF_XL : reg_addr + 8'h01;

  assign ctrl_wr   = reg_wr && (reg_addr == `PSF_ADDR_MODE_CTRL);
  assign clear_buf = ctrl_wr && (reg_wdata[`PSF_MODE_MSB:`PSF_MODE_LSB] == 2'b00);
  assign ia_rise   = interrupt_active & ~ia_prev_q;

  // Usable depth shrinks to the watermark when requested
  assign depth_limit = (stop_at_watermark && watermark_level != 7'd0) ?
                       {1'b0, watermark_level} : `PSF_DEPTH;

  // Behaviour selection from mode code and trigger history
  always @* begin
    case (mode_code)
      3'b001: behave = B_FIFO;
      3'b011: behave = B_CONT;
      3'b101: behave = trig_seen_q ? B_FIFO : B_BYPASS;
      3'b110: behave = trig_seen_q ? B_CONT : B_BYPASS;
      3'b111: behave = trig_seen_q ? B_FIFO : B_CONT;
      default: behave = B_BYPASS;
    endcase
  end

  assign pop = reg_rd && (reg_addr == `PSF_ADDR_BUF_H) && (count_q != 8'h00);

  always @* begin
    push        = 1'b0;
    drop_oldest = 1'b0;
    if (take) begin
      case (behave)
        B_FIFO: begin
          push = (count_q < depth_limit);
        end
        B_CONT: begin
          push        = 1'b1;
          drop_oldest = (count_q >= depth_limit);
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end
  end

  always @* begin
    count_d = count_q;
    if (push && !drop_oldest && !pop) begin
      count_d = count_q + 8'h01;
    end else if (pop && !(push && !drop_oldest)) begin
      count_d = count_q - 8'h01;
    end
  end

  assign wtm_flag  = (watermark_level != 7'd0) && (count_q >= {1'b0, watermark_level});
  assign full_flag = (count_q >= depth_limit);
  assign head      = buf_mem[rd_ptr_q];

  always @(posedge sys_clk) begin
    if (push) begin
      buf_mem[wr_ptr_q] <= st_data[23:0];
    end
  end

  // Buffer pointers, count and overrun
  always @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_q <= 7'd0;
      rd_ptr_q <= 7'd0;
      count_q  <= 8'h00;
      ovr_q    <= 1'b0;
    end else if (clear_buf) begin
      wr_ptr_q <= 7'd0;
      rd_ptr_q <= 7'd0;
      count_q  <= 8'h00;
      ovr_q    <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 7'd1;
      end
      if (pop || drop_oldest) begin
        rd_ptr_q <= rd_ptr_q + 7'd1;
      end
      if (drop_oldest && pop) begin
        rd_ptr_q <= rd_ptr_q + 7'd2;
      end
      count_q <= count_d;
      if (drop_oldest) begin
        ovr_q <= 1'b1;
      end else if (reg_rd && reg_addr == `PSF_ADDR_FLAG_STATUS) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Trigger history for the triggered modes
  always @(posedge sys_clk) begin
    if (reset) begin
      trig_seen_q <= 1'b0;
      ia_prev_q   <= 1'b0;
    end else begin
      ia_prev_q <= interrupt_active;
      if (ctrl_wr) begin
        trig_seen_q <= 1'b0;
      end else if (ia_rise && mode_code[2] && mode_code != 3'b100) begin
        trig_seen_q <= 1'b1;
      end
    end
  end

  // Result registers always carry the latest conversion
  always @(posedge sys_clk) begin
    if (reset) begin
      press_q <= `PSF_RST_PRESS;
      temp_q  <= `PSF_RST_TEMP;
      drdy_q  <= 1'b0;
    end else begin
      if (take) begin
        press_q <= st_data[23:0];
        temp_q  <= st_data[39:24];
      end
      if (take) begin
        drdy_q <= 1'b1;
      end else if (reg_rd && reg_addr == `PSF_ADDR_PRESS_H) begin
        drdy_q <= 1'b0;
      end
    end
  end

  // Configuration registers
  always @(posedge sys_clk) begin
    if (reset) begin
      thresh_cfg_q <= `PSF_RST_BYTE;
      int_route_q  <= `PSF_RST_BYTE;
      mode_ctrl_q  <= `PSF_RST_BYTE;
      wtm_level_q  <= `PSF_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `PSF_ADDR_THRESH_CFG: thresh_cfg_q <= reg_wdata;
        `PSF_ADDR_INT_ROUTE:  int_route_q  <= reg_wdata;
        `PSF_ADDR_MODE_CTRL:  mode_ctrl_q  <= reg_wdata;
        `PSF_ADDR_WTM_LEVEL:  wtm_level_q  <= {1'b0, reg_wdata[6:0]};
        default:              thresh_cfg_q <= thresh_cfg_q;
      endcase
    end
  end

  // Read multiplexer
  always @* begin
    case (reg_addr)
      `PSF_ADDR_THRESH_CFG:   rdata_d = thresh_cfg_q;
      `PSF_ADDR_INT_ROUTE:    rdata_d = int_route_q;
      `PSF_ADDR_MODE_CTRL:    rdata_d = mode_ctrl_q;
      `PSF_ADDR_WTM_LEVEL:    rdata_d = wtm_level_q;
      `PSF_ADDR_INT_SOURCE:   rdata_d = interrupt_source;
      `PSF_ADDR_SAMPLE_COUNT: rdata_d = count_q;
      `PSF_ADDR_FLAG_STATUS:  rdata_d = {wtm_flag, ovr_q, full_flag, 5'b00000};
      `PSF_ADDR_PRESS_XL:     rdata_d = press_q[7:0];
      `PSF_ADDR_PRESS_L:      rdata_d = press_q[15:8];
      `PSF_ADDR_PRESS_H:      rdata_d = press_q[23:16];
      `PSF_ADDR_TEMP_L:       rdata_d = temp_q[7:0];
      `PSF_ADDR_TEMP_H:       rdata_d = temp_q[15:8];
      `PSF_ADDR_BUF_XL:       rdata_d = (count_q != 8'h00) ? head[7:0] : 8'h00;
      `PSF_ADDR_BUF_L:        rdata_d = (count_q != 8'h00) ? head[15:8] : 8'h00;
      `PSF_ADDR_BUF_H:        rdata_d = (count_q != 8'h00) ? head[23:16] : 8'h00;
      default:                rdata_d = 8'h00;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata           <= 8'h00;
      interrupt_ready_pin <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      interrupt_ready_pin <= (int_route_q[`PSF_EN_DRDY_BIT] & drdy_q) |
                             (int_route_q[`PSF_EN_OVR_BIT] & ovr_q) |
                             (int_route_q[`PSF_EN_WTM_BIT] & wtm_flag) |
                             (int_route_q[`PSF_EN_FULL_BIT] & full_flag);
    end
  end
endmodule

// ### bench/psf_core_sva.sv
/*
  Checker for psf_core: register bus answers, burst address, trim load and flag relations.
  Assumes it is bound to psf_core and sees only that module's ports.
*/
`timescale 1ns/1ps
module psf_core_sva (
  input logic       sys_clk,
  input logic       reset,
  input logic [7:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic [7:0] reg_next_addr,
  input logic [7:0] threshold_interrupt_config,
  input logic       interrupt_ready_pin,
  input logic       nv_rd_en,
  input logic       trim_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic [6:0] wtm_q;
  logic [7:0] route_q;

  // Shadow copies of the watermark level and the interrupt routing enables
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wtm_q   <= 7'h00;
      route_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h15) wtm_q <= reg_wdata[6:0];
      if (reg_addr == 8'h12) route_q <= reg_wdata;
    end
  end

  addr_wrap_a: assert property (reg_addr == 8'h7a |-> reg_next_addr == 8'h78)
    else $error("burst address does not wrap to 78h");
  addr_step_a: assert property (reg_addr != 8'h7a |-> reg_next_addr == reg_addr + 8'h01)
    else $error("burst address does not step by one");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  thresh_cfg_a: assert property (reg_wr && reg_addr == 8'h0b |=> threshold_interrupt_config == $past(reg_wdata))
    else $error("threshold config not written");
  bypass_clear_a: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata[1:0] == 2'b00 ##[1:2]
    (reg_rd && reg_addr == 8'h25) |=> reg_rdata == 8'h00) else $error("bypass left stored samples");
  wtm_zero_a: assert property (reg_rd && reg_addr == 8'h26 && wtm_q == 7'h00 |=> !reg_rdata[7])
    else $error("watermark flag with level zero");
  route_off_a: assert property (route_q == 8'h00 |=> !interrupt_ready_pin)
    else $error("pin raised with all events disabled");
  trim_quiet_a: assert property (trim_done |-> !nv_rd_en)
    else $error("storage read after trim load finished");
  trim_time_a: assert property ($fell(reset) |-> ##[1:12] trim_done)
    else $error("trim load did not finish in time");

  cover property (reg_rd && reg_addr == 8'h7a);
  cover property (reg_wr && reg_addr == 8'h14);
  cover property (interrupt_ready_pin);
endmodule

bind psf_core psf_core_sva u_sva (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_next_addr, .threshold_interrupt_config, .interrupt_ready_pin, .nv_rd_en, .trim_done);

// ### bench/psf_host_model.sv
/*
  Host side model: single-cycle register strobes and the trim storage.
  Assumes psf_core takes strobes at rising edges and answers reads one cycle later.
*/
`timescale 1ns/1ps
module psf_host_model (
  input  logic       sys_clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_wdata,
  input  logic [7:0] reg_rdata,
  input  logic [1:0] nv_rd_addr,
  input  logic       nv_rd_en,
  output logic [7:0] nv_rd_data
);
  initial begin
    reg_addr   = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_wdata  = 8'h00;
    nv_rd_data = 8'h00;
  end

  // Released address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  // Storage byte i holds 3ch xor i, returned one cycle after the request
  always @(posedge sys_clk) begin
    nv_rd_data <= nv_rd_en ? (8'h3c ^ {6'h00, nv_rd_addr}) : ~nv_rd_data;
  end
endmodule

// ### bench/testbench.sv
/*
  Self-checking bench for psf_core: registers, results, buffer modes and trim load.
  Assumes psf_host_model for register traffic and the bound psf_core_sva checker.
*/
`timescale 1ns/1ps
module testbench;
  logic        sys_clk;
  logic        reset;
  logic        reg_wr;
  logic        reg_rd;
  logic        sample_valid;
  logic        sample_ready;
  logic        interrupt_active;
  logic        interrupt_ready_pin;
  logic        nv_rd_en;
  logic        trim_done;
  logic [1:0]  nv_rd_addr;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, reg_next_addr, interrupt_source, nv_rd_data, b;
  logic [7:0]  threshold_interrupt_config;
  logic [15:0] sample_temperature;
  logic [23:0] sample_pressure;
  logic [31:0] trim_values;
  int          n_errors;
  int          n_checks;
  int          cycles;

  psf_core u_dut (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_next_addr,
    .sample_pressure, .sample_temperature, .sample_valid, .sample_ready, .interrupt_active, .interrupt_source,
    .threshold_interrupt_config, .interrupt_ready_pin, .nv_rd_addr, .nv_rd_en, .nv_rd_data, .trim_values,
    .trim_done);
  psf_host_model u_host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .nv_rd_addr,
    .nv_rd_en, .nv_rd_data);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, b);
    chk({24'h0, b}, {24'h0, exp}, $sformatf("read of %h", a));
  endtask

  function automatic logic [23:0] pval(input int i);
    return {i[7:0] ^ 8'h80, ~i[7:0], i[7:0]};
  endfunction

  // Offers samples first..first+n-1, then lets the staging buffer empty
  task automatic push(input int first, input int n);
    @(posedge sys_clk);
    for (int i = first; i < first + n; i++) begin
      sample_pressure    <= pval(i);
      sample_temperature <= {8'h09, i[7:0]};
      sample_valid       <= 1'b1;
      @(negedge sys_clk);
      while (sample_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    sample_valid <= 1'b0;
    repeat (24) @(posedge sys_clk);
  endtask

  task automatic drain(input int first, input int n);
    logic [23:0] p;
    for (int i = first; i < first + n; i++) begin
      p = pval(i);
      rdc(8'h78, p[7:0]);
      rdc(8'h79, p[15:8]);
      rdc(8'h7a, p[23:16]);
    end
  endtask

  task automatic set_mode(input logic [7:0] m);
    u_host.wr(8'h14, 8'h00);
    u_host.wr(8'h14, m);
  endtask

  task automatic t_reset();
    logic [7:0] regs [6] = '{8'h12, 8'h14, 8'h15, 8'h25, 8'h26, 8'h00};
    while (trim_done !== 1'b1) @(posedge sys_clk);
    chk(trim_values, 32'h3f3e3d3c, "trim values");
    foreach (regs[k]) rdc(regs[k], 8'h00);
    u_host.wr(8'h25, 8'hff);
    rdc(8'h25, 8'h00);
    rdc(8'h24, 8'ha5);
    u_host.wr(8'h0b, 8'h81);
    @(negedge sys_clk);
    chk({24'h0, threshold_interrupt_config}, 32'h81, "threshold config");
  endtask

  task automatic t_results();
    u_host.wr(8'h12, 8'h01);
    push(9, 1);
    chk({31'h0, interrupt_ready_pin}, 32'h1, "data ready");
    rdc(8'h28, 8'h09);
    rdc(8'h29, 8'hf6);
    rdc(8'h2a, 8'h89);
    rdc(8'h2b, 8'h09);
    rdc(8'h2c, 8'h09);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, interrupt_ready_pin}, 32'h0, "data ready cleared");
    push(10, 2);
    rdc(8'h28, 8'h0b);
    rdc(8'h25, 8'h00);
    u_host.wr(8'h12, 8'h00);
  endtask

  task automatic t_fifo();
    set_mode(8'h01);
    push(0, 130);
    rdc(8'h25, 8'h80);
    rdc(8'h26, 8'h20);
    drain(0, 128);
    rdc(8'h25, 8'h00);
    rdc(8'h78, 8'h00);
  endtask

  task automatic t_watermark();
    u_host.wr(8'h15, 8'h83);
    rdc(8'h15, 8'h03);
    set_mode(8'h09);
    push(0, 5);
    rdc(8'h25, 8'h03);
    rdc(8'h26, 8'ha0);
    u_host.wr(8'h12, 8'h08);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, interrupt_ready_pin}, 32'h1, "watermark on pin");
    u_host.wr(8'h12, 8'h10);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, interrupt_ready_pin}, 32'h1, "full on pin");
    u_host.wr(8'h15, 8'h00);
    rdc(8'h26, 8'h00);
    chk({31'h0, interrupt_ready_pin}, 32'h0, "full cleared on pin");
    u_host.wr(8'h12, 8'h00);
    drain(0, 1);
    rdc(8'h25, 8'h02);
  endtask

  task automatic t_continuous();
    set_mode(8'h03);
    u_host.wr(8'h12, 8'h04);
    push(0, 130);
    chk({31'h0, interrupt_ready_pin}, 32'h1, "overrun on pin");
    rdc(8'h25, 8'h80);
    rdc(8'h26, 8'h60);
    rdc(8'h26, 8'h20);
    drain(2, 1);
    rdc(8'h25, 8'h7f);
    u_host.wr(8'h14, 8'h00);
    rdc(8'h25, 8'h00);
    u_host.wr(8'h14, 8'h03);
    push(0, 1);
    u_host.wr(8'h14, 8'h04);
    rdc(8'h25, 8'h00);
    u_host.wr(8'h14, 8'h02);
    push(0, 1);
    rdc(8'h25, 8'h00);
    u_host.wr(8'h12, 8'h00);
  endtask

  task automatic t_triggered();
    logic [7:0] codes [3] = '{8'h05, 8'h06, 8'h07};
    logic [7:0] pre;
    u_host.wr(8'h0b, 8'h01);
    foreach (codes[k]) begin
      pre = (codes[k] == 8'h07) ? 8'h02 : 8'h00;
      set_mode(codes[k]);
      push(0, 2);
      rdc(8'h25, pre);
      @(posedge sys_clk);
      interrupt_active <= 1'b1;
      push(2, 130);
      interrupt_active <= 1'b0;
      rdc(8'h25, 8'h80);
      rdc(8'h26, (codes[k] == 8'h06) ? 8'h60 : 8'h20);
    end
    u_host.wr(8'h14, 8'h00);
  endtask

  initial begin
    reset              = 1'b1;
    sample_valid       = 1'b0;
    sample_pressure    = 24'h000000;
    sample_temperature = 16'h0000;
    interrupt_active   = 1'b0;
    interrupt_source   = 8'ha5;
    n_errors           = 0;
    n_checks           = 0;
    cycles             = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_results();
    t_fifo();
    t_watermark();
    t_continuous();
    t_triggered();
    stop_test();
  end
endmodule
